// [txps_consts.svh]
`ifndef TXPS_CONSTS_SVH
`define TXPS_CONSTS_SVH
`define TXPS_MCLK_KHZ     250000
`define TXPS_INTCLK_KHZ   3200
`define TXPS_DIV          (`TXPS_MCLK_KHZ / `TXPS_INTCLK_KHZ)
`define TXPS_IDLE_TICKS   4096
`define TXPS_I2C_ADDR     7'h69
`define TXPS_A_MOD        8'h00
`define TXPS_A_PWR        8'h03
`define TXPS_A_TRIG_LO    8'h0A
`define TXPS_A_TRIG_HI    8'h10
`define TXPS_A_LEN        8'h11
`define TXPS_A_TXPORT     8'h13
`define TXPS_A_SYNTH      8'h1A
`define TXPS_SYNTH_RST    8'h80
`define TXPS_TRIG_BIT     2
`define TXPS_MODSEL_BIT   0
`define TXPS_LENMODE_BIT  7
`define TXPS_PWR_SHUT     2'h0
`define TXPS_PWR_STBY     2'h1
`define TXPS_PWR_PROG     2'h2
`define TXPS_BYTE_BITS    4'h8
`define TXPS_ACK_BIT      4'h9
`define TXPS_PA_MAX       4'hF
`define TXPS_PIN_INIT     5'h1E
`define TXPS_P_DATA       0
`define TXPS_P_SCL        1
`define TXPS_P_SDA        2
`define TXPS_P_SELA       3
`define TXPS_P_SELB       4
`endif

// [txps_pkg.sv]
package txps_pkg;
  typedef enum logic [4:0] {
    ST_SHUT = 5'h01,
    ST_STBY = 5'h02,
    ST_WARM = 5'h04,
    ST_PROG = 5'h08,
    ST_TX   = 5'h10
  } txps_state_t;
  typedef enum logic [4:0] {
    I_IDLE = 5'h01,
    I_ADDR = 5'h02,
    I_REG  = 5'h04,
    I_DATA = 5'h08,
    I_SKIP = 5'h10
  } txps_phase_t;
endpackage : txps_pkg

// [txps_sync3.sv]
module txps_sync3 #(
  parameter int             W    = 5,
  parameter logic [W-1:0]   INIT = '0
) (
  input  wire logic         mclk_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] lvl_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_lvl;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1    <= INIT;
      s2    <= INIT;
      s3    <= INIT;
      lvl_o <= INIT;
    end else begin
      s1    <= d_i;
      s2    <= s1;
      s3    <= s2;
      lvl_o <= next_lvl;
    end
  end

  // level follows only when stages two and three agree
  assign next_lvl = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & lvl_o);
  assign rise_o   = next_lvl & ~lvl_o;
  assign fall_o   = ~next_lvl & lvl_o;
endmodule : txps_sync3

// [txps_buf2.sv]
module txps_buf2 #(
  parameter int W = 8
) (
  input  wire logic         mclk_i,
  input  wire logic         reset_n_i,
  input  wire logic         flush_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);
  logic [W-1:0] mem [2];
  logic         wr_ptr;
  logic         rd_ptr;
  logic [1:0]   count;
  logic         push;
  logic         pop;

  assign in_ready_o  = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else if (flush_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= 2'(count + {1'b0, push} - {1'b0, pop});
    end
  end
endmodule : txps_buf2

// [txps_sequencer.sv]
// Functional notes
// - preset mode uses only shutdown, warm-up and transmit; shutdown turns oscillator, synth, amp off.
// - transmit state runs oscillator and synth, amplifier ramps up gradually.
// - reset lands in shutdown before anything else.
// - preset mode rising data edge starts oscillator and synth warm-up.
// - preset mode after lock, falling data edge enters transmit.
// - preset mode data low for 4096 internal ticks returns to shutdown.
// - serial mode has four states; programming runs oscillator and synth, amp off.
// - standby keeps only the oscillator running.
// - own 7-bit address on the bus wakes oscillator and synth.
// - rising edge of trigger bit starts transmission; aliased at 0x0A and 0x10 bit 2.
// - trigger auto-clears on wake from shutdown and on transmit-to-programming.
// - bytes to 0x13 go to the buffer only in transmit; burst pointer stops there.
// - transmission end raises done and picks next state from 0x03 bits 1:0.
// - standby and shutdown refuse writes; address receipt leaves them.
// - repeated start re-sends address; device accepts combined transactions.
// - configuration survives state changes; only reset clears it.
// - serial mode only when both select pins low; bus up to 1MHz.
`include "txps_consts.svh"
module txps_sequencer
  import txps_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       reset_n_i,
  input  wire logic       select_pin_a_i,
  input  wire logic       select_pin_b_i,
  input  wire logic       data_i,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe_o,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic       synth_lock_i,
  input  wire logic       fifo_stop_i,
  output logic            crystal_oscillator_en_o,
  output logic            synth_en_o,
  output logic            pa_en_o,
  output logic [3:0]      pa_level_o,
  output logic            transmit_trigger_o,
  output logic            tx_start_o,
  output logic            tx_done_o,
  output logic            modulation_select_o,
  output logic            length_limit_enable_o,
  output logic [7:0]      synth_init_o,
  output logic [4:0]      state_o,
  output logic [7:0]      tx_byte_o,
  output logic            tx_byte_valid_o,
  input  wire logic       tx_byte_ready_i
);
  logic [4:0]  pin_lvl;
  logic [4:0]  pin_rise;
  logic [4:0]  pin_fall;
  logic        i2c_mode;
  logic [6:0]  div_cnt;
  logic        tick;
  logic [12:0] idle_cnt;
  logic        idle;
  txps_state_t state;
  txps_state_t next_state;
  txps_phase_t phase;
  logic [3:0]  bit_cnt;
  logic [7:0]  shift;
  logic [7:0]  ptr;
  logic        ack_drv;
  logic        pend;
  logic        byte_done;
  logic        addr_hit;
  logic        wake;
  logic        reg_we;
  logic        trig;
  logic        trig_q;
  logic        trig_rise;
  logic        stop_q;
  logic        stop_rise;
  logic [1:0]  post_tx_power_state;
  logic        buf_ready;

  function automatic logic is_alias(input logic [7:0] a);
    return (a == `TXPS_A_TRIG_LO) || (a == `TXPS_A_TRIG_HI);
  endfunction : is_alias

  function automatic logic write_ok(input txps_state_t s);
    return (s == ST_PROG) || (s == ST_TX);
  endfunction : write_ok

  txps_sync3 #(.W(5), .INIT(`TXPS_PIN_INIT)) u_sync (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .d_i       ({select_pin_b_i, select_pin_a_i, sda_i, scl_i, data_i}),
    .lvl_o     (pin_lvl),
    .rise_o    (pin_rise),
    .fall_o    (pin_fall)
  );

  assign i2c_mode = !pin_lvl[`TXPS_P_SELA] && !pin_lvl[`TXPS_P_SELB];

  // internal clock enable
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_cnt <= 7'h00;
    end else if (tick) begin
      div_cnt <= 7'h00;
    end else begin
      div_cnt <= 7'(div_cnt + 7'h01);
    end
  end
  assign tick = (div_cnt == 7'(`TXPS_DIV - 1));

  // data inactivity count
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idle_cnt <= 13'h0000;
    end else if (pin_lvl[`TXPS_P_DATA] || pin_rise[`TXPS_P_DATA] || state == ST_SHUT) begin
      idle_cnt <= 13'h0000;
    end else if (tick && !idle) begin
      idle_cnt <= 13'(idle_cnt + 13'h0001);
    end
  end
  assign idle = (idle_cnt == 13'(`TXPS_IDLE_TICKS));

  // power state machine
  always_comb begin
    next_state = state;
    case (state)
      ST_SHUT: begin
        if (!i2c_mode && pin_rise[`TXPS_P_DATA]) begin
          next_state = ST_WARM;
        end else if (wake) begin
          next_state = ST_PROG;
        end
      end
      ST_STBY: begin
        if (!i2c_mode) begin
          next_state = ST_SHUT;
        end else if (wake) begin
          next_state = ST_PROG;
        end
      end
      ST_WARM: begin
        if (i2c_mode || idle) begin
          next_state = ST_SHUT;
        end else if (synth_lock_i && pin_fall[`TXPS_P_DATA]) begin
          next_state = ST_TX;
        end
      end
      ST_PROG: begin
        if (!i2c_mode) begin
          next_state = ST_SHUT;
        end else if (trig_rise) begin
          next_state = ST_TX;
        end
      end
      ST_TX: begin
        if (!i2c_mode) begin
          if (idle) begin
            next_state = ST_SHUT;
          end
        end else if (stop_rise) begin
          case (post_tx_power_state)
            `TXPS_PWR_SHUT: next_state = ST_SHUT;
            `TXPS_PWR_STBY: next_state = ST_STBY;
            default:        next_state = ST_PROG;
          endcase
        end
      end
      default: next_state = ST_SHUT;
    endcase
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ST_SHUT;
    end else begin
      state <= next_state;
    end
  end

  // supply enables per state
  assign crystal_oscillator_en_o = (state != ST_SHUT);
  assign synth_en_o = (state == ST_WARM) || (state == ST_PROG) || (state == ST_TX);
  assign pa_en_o = (state == ST_TX);
  assign state_o = state;

  // amplifier ramp
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pa_level_o <= 4'h0;
    end else if (state != ST_TX) begin
      pa_level_o <= 4'h0;
    end else if (tick && pa_level_o != `TXPS_PA_MAX) begin
      pa_level_o <= 4'(pa_level_o + 4'h1);
    end
  end

  // serial slave, write side
  assign byte_done = pin_fall[`TXPS_P_SCL] && (bit_cnt == `TXPS_BYTE_BITS);
  assign addr_hit  = byte_done && (phase == I_ADDR) && (shift[7:1] == `TXPS_I2C_ADDR);
  assign wake      = i2c_mode && addr_hit;
  assign reg_we    = byte_done && (phase == I_DATA) && (ptr != `TXPS_A_TXPORT) && write_ok(state);

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase   <= I_IDLE;
      bit_cnt <= 4'h0;
      shift   <= 8'h00;
      ptr     <= 8'h00;
      ack_drv <= 1'b0;
      pend    <= 1'b0;
    end else if (!i2c_mode) begin
      phase   <= I_IDLE;
      ack_drv <= 1'b0;
      pend    <= 1'b0;
    end else if (pin_fall[`TXPS_P_SDA] && pin_lvl[`TXPS_P_SCL]) begin
      phase   <= I_ADDR;
      bit_cnt <= 4'h0;
      ack_drv <= 1'b0;
    end else if (pin_rise[`TXPS_P_SDA] && pin_lvl[`TXPS_P_SCL]) begin
      phase   <= I_IDLE;
      ack_drv <= 1'b0;
    end else if (pend) begin
      if (buf_ready) begin
        pend    <= 1'b0;
        ack_drv <= 1'b1;
      end
    end else if (pin_rise[`TXPS_P_SCL] && bit_cnt < `TXPS_BYTE_BITS) begin
      shift   <= {shift[6:0], pin_lvl[`TXPS_P_SDA]};
      bit_cnt <= 4'(bit_cnt + 4'h1);
    end else if (pin_rise[`TXPS_P_SCL]) begin
      bit_cnt <= `TXPS_ACK_BIT;
    end else if (pin_fall[`TXPS_P_SCL] && bit_cnt == `TXPS_ACK_BIT) begin
      ack_drv <= 1'b0;
      bit_cnt <= 4'h0;
    end else if (byte_done) begin
      case (phase)
        I_ADDR: begin
          ack_drv <= addr_hit;
          if (!addr_hit) begin
            phase <= I_IDLE;
          end else if (shift[0]) begin
            phase <= I_SKIP;
          end else begin
            phase <= I_REG;
          end
        end
        I_REG: begin
          ptr     <= shift;
          phase   <= I_DATA;
          ack_drv <= 1'b1;
        end
        I_DATA: begin
          if (ptr == `TXPS_A_TXPORT) begin
            pend    <= (state == ST_TX);
            ack_drv <= (state != ST_TX);
          end else begin
            ack_drv <= write_ok(state);
            ptr     <= 8'(ptr + 8'h01);
          end
        end
        default: begin
          ack_drv <= 1'b0;
        end
      endcase
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = ack_drv;
  assign scl_o    = 1'b0;
  assign scl_oe_o = pend;

  // configuration registers, kept until reset
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      modulation_select_o   <= 1'b0;
      post_tx_power_state   <= `TXPS_PWR_SHUT;
      length_limit_enable_o <= 1'b0;
      synth_init_o          <= `TXPS_SYNTH_RST;
    end else if (reg_we) begin
      case (ptr)
        `TXPS_A_MOD:   modulation_select_o   <= shift[`TXPS_MODSEL_BIT];
        `TXPS_A_PWR:   post_tx_power_state   <= shift[1:0];
        `TXPS_A_LEN:   length_limit_enable_o <= shift[`TXPS_LENMODE_BIT];
        `TXPS_A_SYNTH: synth_init_o          <= shift;
        default:       synth_init_o          <= synth_init_o;
      endcase
    end
  end

  // transmit trigger bit and its edge
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trig <= 1'b0;
    end else if (reg_we && is_alias(ptr)) begin
      trig <= shift[`TXPS_TRIG_BIT];
    end else if ((state == ST_SHUT || state == ST_TX) && next_state == ST_PROG) begin
      trig <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trig_q     <= 1'b0;
      stop_q     <= 1'b0;
      tx_start_o <= 1'b0;
      tx_done_o  <= 1'b0;
    end else begin
      trig_q     <= trig;
      stop_q     <= fifo_stop_i;
      tx_start_o <= (state != ST_TX) && (next_state == ST_TX);
      tx_done_o  <= stop_rise && (state == ST_TX);
    end
  end
  assign trig_rise          = trig && !trig_q;
  assign stop_rise          = fifo_stop_i && !stop_q;
  assign transmit_trigger_o = trig;

  txps_buf2 #(.W(8)) u_buf (
    .mclk_i      (mclk_i),
    .reset_n_i   (reset_n_i),
    .flush_i     (state != ST_TX),
    .in_valid_i  (pend),
    .in_ready_o  (buf_ready),
    .in_data_i   (shift),
    .out_valid_o (tx_byte_valid_o),
    .out_ready_i (tx_byte_ready_i),
    .out_data_o  (tx_byte_o)
  );

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_own_addr;
    addr_hit && i2c_mode;
  endsequence

  sequence s_trig_edge;
    state == ST_PROG && i2c_mode ##0 trig_rise;
  endsequence

  a_shut_all_off: assert property (state == ST_SHUT |-> !crystal_oscillator_en_o && !synth_en_o && !pa_en_o)
    else $error("shutdown with a supply on");
  a_tx_pa_ramp: assert property (state == ST_TX && tick && pa_level_o != `TXPS_PA_MAX && $stable(state)
    |=> pa_level_o == $past(pa_level_o) + 4'h1 || state != ST_TX)
    else $error("amplifier ramp stalled");
  a_preset_wake: assert property (state == ST_SHUT && !i2c_mode && pin_rise[`TXPS_P_DATA] |=> state == ST_WARM)
    else $error("data edge did not start warm-up");
  a_preset_txen: assert property (state == ST_WARM && !i2c_mode && !idle && synth_lock_i && pin_fall[`TXPS_P_DATA]
    |=> state == ST_TX && tx_start_o)
    else $error("locked falling edge did not enable transmit");
  a_idle_shut: assert property ((state == ST_WARM || state == ST_TX) && !i2c_mode && idle |=> state == ST_SHUT)
    else $error("idle data did not shut down");
  a_standby_xo: assert property (state == ST_STBY |-> crystal_oscillator_en_o && !synth_en_o && !pa_en_o)
    else $error("standby supplies wrong");
  a_addr_wake: assert property (s_own_addr ##0 (state == ST_SHUT || state == ST_STBY)
    |=> state == ST_PROG ##1 synth_en_o)
    else $error("own address did not wake device");
  a_trig_start: assert property (s_trig_edge |=> state == ST_TX && tx_start_o)
    else $error("trigger edge did not start transmit");
  a_trig_clear: assert property (s_own_addr ##0 state == ST_SHUT |=> !trig)
    else $error("trigger not cleared on wake");
  a_port_sticks: assert property (byte_done && phase == I_DATA && ptr == `TXPS_A_TXPORT |=> ptr == `TXPS_A_TXPORT)
    else $error("pointer left byte port");
  a_done_state: assert property (state == ST_TX && i2c_mode && stop_rise && post_tx_power_state == `TXPS_PWR_STBY
    |=> state == ST_STBY && tx_done_o)
    else $error("post-transmit state wrong");
  a_refuse_write: assert property ((state == ST_SHUT || state == ST_STBY) |-> !reg_we)
    else $error("write accepted while asleep");
endmodule : txps_sequencer

// [txps_host_model.sv]
module txps_host_model (
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_low_o,
  output logic      sda_low_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end

  // start, also repeated start with address re-sent by caller
  task automatic start_bit;
    sda_low_o = 1'b0;
    #16;
    scl_low_o = 1'b0;
    #16;
    sda_low_o = 1'b1;
    #16;
    scl_low_o = 1'b1;
    #16;
  endtask : start_bit

  // one clock; waits out a stretch, bounded
  task automatic clk_bit(input logic b, output logic seen);
    int n;
    sda_low_o = !b;
    #16;
    scl_low_o = 1'b0;
    n = 0;
    while (scl_i !== 1'b1 && n < 5000) begin
      #4;
      n++;
    end
    #16;
    seen = sda_i;
    #16;
    scl_low_o = 1'b1;
    #16;
  endtask : clk_bit

  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(v[i], s);
    clk_bit(1'b1, s);
    ack = !s;
  endtask : send_byte

  task automatic stop_bit;
    sda_low_o = 1'b1;
    #16;
    scl_low_o = 1'b0;
    #16;
    sda_low_o = 1'b0;
    #32;
  endtask : stop_bit
endmodule : txps_host_model

// [tx_power_state_sequencer_tb_top.sv]
`include "txps_consts.svh"
module tx_power_state_sequencer_tb_top
  import txps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic mclk_i, reset_n_i, select_pin_a_i, select_pin_b_i, data_i;
  logic synth_lock_i, fifo_stop_i, tx_byte_ready_i;
  logic scl_o, scl_oe_o, sda_o, sda_oe_o, scl_low, sda_low, scl_line, sda_line;
  logic crystal_oscillator_en_o, synth_en_o, pa_en_o, transmit_trigger_o;
  logic tx_start_o, tx_done_o, modulation_select_o, length_limit_enable_o;
  logic tx_byte_valid_o, stall, stretched;
  logic [3:0] pa_level_o;
  logic [7:0] synth_init_o, tx_byte_o;
  logic [4:0] state_o;
  logic [2:0] en3;
  logic [7:0] got[$];
  int         seed, mismatches, cmp_count, starts, dones;

  assign scl_line = !((scl_oe_o && !scl_o) || scl_low);
  assign sda_line = !((sda_oe_o && !sda_o) || sda_low);
  assign en3 = {crystal_oscillator_en_o, synth_en_o, pa_en_o};

  txps_sequencer dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .select_pin_a_i(select_pin_a_i),
    .select_pin_b_i(select_pin_b_i), .data_i(data_i), .scl_i(scl_line), .scl_o(scl_o),
    .scl_oe_o(scl_oe_o), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .synth_lock_i(synth_lock_i), .fifo_stop_i(fifo_stop_i),
    .crystal_oscillator_en_o(crystal_oscillator_en_o), .synth_en_o(synth_en_o), .pa_en_o(pa_en_o),
    .pa_level_o(pa_level_o), .transmit_trigger_o(transmit_trigger_o), .tx_start_o(tx_start_o),
    .tx_done_o(tx_done_o), .modulation_select_o(modulation_select_o),
    .length_limit_enable_o(length_limit_enable_o), .synth_init_o(synth_init_o), .state_o(state_o),
    .tx_byte_o(tx_byte_o), .tx_byte_valid_o(tx_byte_valid_o), .tx_byte_ready_i(tx_byte_ready_i));

  txps_host_model host (.scl_i(scl_line), .sda_i(sda_line), .scl_low_o(scl_low), .sda_low_o(sda_low));

  always #2 mclk_i = ~mclk_i;

  always @(negedge mclk_i) tx_byte_ready_i <= !stall && (($random(seed) & 1) == 1);
  always @(posedge mclk_i) begin
    if (tx_byte_valid_o === 1'b1 && tx_byte_ready_i) got.push_back(tx_byte_o);
    if (scl_oe_o === 1'b1) stretched = 1'b1;
    if (tx_start_o === 1'b1) starts++;
    if (tx_done_o === 1'b1) dones++;
  end

  function automatic logic [4:0] post_state(input logic [1:0] pw);
    return (pw == `TXPS_PWR_SHUT) ? ST_SHUT : (pw == `TXPS_PWR_STBY) ? ST_STBY : ST_PROG;
  endfunction : post_state

  function automatic logic [2:0] en_of(input logic [4:0] st);
    return {st != ST_SHUT, st == ST_WARM || st == ST_PROG || st == ST_TX, st == ST_TX};
  endfunction : en_of

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : chk

  task automatic xfer(input logic [7:0] ra, input logic [7:0] d[$], output logic ok);
    logic a;
    host.start_bit();
    host.send_byte({`TXPS_I2C_ADDR, 1'b0}, ok);
    host.send_byte(ra, a);
    ok &= a;
    foreach (d[i]) begin
      host.send_byte(d[i], a);
      ok &= a;
    end
  endtask : xfer

  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : wait_n

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  initial begin
    #200000;
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    wrap_up();
  end

  initial begin
    logic       ok;
    logic       m;
    logic [1:0] pw;
    logic [7:0] d[$];
    logic [7:0] pay[$];
    int         s0;
    mclk_i = 0; reset_n_i = 0; select_pin_a_i = 0; select_pin_b_i = 0; data_i = 0;
    synth_lock_i = 0; fifo_stop_i = 0; stall = 1; stretched = 0; seed = 79229;
    wait_n(8);
    reset_n_i = 1;
    chk(state_o, ST_SHUT);
    chk(en3, 3'b000);
    chk(synth_init_o, `TXPS_SYNTH_RST);
    wait_n(8);
    host.start_bit();
    host.send_byte({`TXPS_I2C_ADDR ^ 7'h01, 1'b0}, ok);
    host.stop_bit();
    chk(ok, 1'b0);
    chk(state_o, ST_SHUT);
    $display("reset and foreign address done");
    for (int k = 0; k < 3; k++) begin
      pw = (k == 2) ? 2'(2 + ($random(seed) & 1)) : 2'(k);
      m = 1'($random(seed));
      d = '{`TXPS_SYNTH_RST};
      xfer(`TXPS_A_SYNTH, d, ok);
      chk(ok, 1'b1);
      chk(state_o, ST_PROG);
      chk(en3, en_of(ST_PROG));
      if (k == 0) chk(transmit_trigger_o, 1'b0);
      d = '{{7'h00, m}, 8'h00, 8'h00, {6'h00, pw}};
      xfer(`TXPS_A_MOD, d, ok);
      host.stop_bit();
      chk(ok, 1'b1);
      chk(modulation_select_o, m);
      pay = {};
      repeat (3) pay.push_back(8'($random(seed)));
      d = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h80, 8'h00};
      d = {d, pay};
      got = {}; stretched = 0; stall = 1; s0 = starts;
      fork
        xfer(`TXPS_A_TRIG_LO, d, ok);
        begin
          wait_n(2400);
          stall = 0;
        end
      join
      host.stop_bit();
      chk(ok, 1'b1);
      chk(stretched, 1'b1);
      chk(8'(starts - s0), 8'd1);
      chk(state_o, ST_TX);
      chk(en3, en_of(ST_TX));
      chk(transmit_trigger_o, 1'b1);
      chk(length_limit_enable_o, 1'b1);
      wait_n(1300);
      chk(pa_level_o, `TXPS_PA_MAX);
      chk(8'(got.size()), 8'd3);
      foreach (pay[i]) if (i < got.size()) chk(got[i], pay[i]);
      s0 = dones;
      fifo_stop_i = 1;
      wait_n(2);
      fifo_stop_i = 0;
      wait_n(4);
      chk(8'(dones - s0), 8'd1);
      chk(state_o, post_state(pw));
      chk(en3, en_of(post_state(pw)));
      chk(pa_level_o, 4'h0);
      if (post_state(pw) == ST_PROG) chk(transmit_trigger_o, 1'b0);
      chk(modulation_select_o, m);
      chk(synth_init_o, `TXPS_SYNTH_RST);
      $display("serial round %0d done", k);
    end
    select_pin_a_i = 1;
    select_pin_b_i = 1;
    wait_n(10);
    chk(state_o, ST_SHUT);
    data_i = 1;
    wait_n(6);
    chk(state_o, ST_WARM);
    chk(en3, en_of(ST_WARM));
    data_i = 0;
    wait_n(6);
    chk(state_o, ST_WARM);
    data_i = 1;
    synth_lock_i = 1;
    wait_n(6);
    data_i = 0;
    wait_n(6);
    chk(state_o, ST_TX);
    chk(en3, en_of(ST_TX));
    $display("preset round done");
    wrap_up();
  end
endmodule : tx_power_state_sequencer_tb_top
